// *** tx_link_insert_pkg.sv ***
// Overview of operation
// - link 1 inserts only in selected frame parity, except at framer positions
// - link 2 inserts only in selected frame parity
// - link 3 inserts only in selected frame parity
// - number frames E1 0-15, T1 1-12/1-24
// - link 1 follows framer positions when enabled, in T1 modes only
// - slot field is binary channel index 0-31
// - both selects zero means link inserts in no slot, link 1 still takes framer positions
// - only mask-one bits of the slot are replaced
// - mask bit 7 is first bit, 0 last
// - three independent links, own source and registers
`default_nettype none
package tx_link_insert_pkg;
  // register word indices, byte address is four times the index
  localparam logic [7:0] IDX_LINK1_CTL = 8'h38;
  localparam logic [7:0] IDX_LINK1_MASK = 8'h39;
  localparam logic [7:0] IDX_LINK2_CTL = 8'h3A;
  localparam logic [7:0] IDX_LINK2_MASK = 8'h3B;
  localparam logic [7:0] IDX_LINK3_CTL = 8'h3C;
  localparam logic [7:0] IDX_LINK3_MASK = 8'h3D;
  localparam logic [7:0] IDX_STATUS = 8'h3E;
  // control register fields
  localparam int BIT_EVEN = 7;
  localparam int BIT_ODD = 6;
  localparam int BIT_FRAMER_POS = 5;
  localparam int SLOT_MSB = 4;
  localparam int SLOT_LSB = 0;
  localparam logic [7:0] CTL_WMASK_LINK23 = 8'hDF;
  localparam logic [2:0] MASK_FIRST_BIT = 3'h7;
  // values after reset
  localparam logic [7:0] CTL1_RESET = 8'h20;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [4:0] FRAME_NUM_RESET = 5'h00;
  // frame numbering within a multiframe
  localparam logic [4:0] E1_FRAME_FIRST = 5'h00;
  localparam logic [4:0] E1_FRAME_LAST = 5'h0F;
  localparam logic [4:0] T1_FRAME_FIRST = 5'h01;
  localparam logic [4:0] SF_FRAME_LAST = 5'h0C;
  localparam logic [4:0] ESF_FRAME_LAST = 5'h18;
  // buffering
  localparam int FIFO_DEPTH = 8;
  localparam int LINKS = 3;
  // one bit of the transmit frame stream
  typedef struct packed {
    logic data;
    logic frame_start;
    logic mf_start;
    logic [4:0] slot;
    logic [2:0] bit_pos;
    logic framer_pos;
  } stream_word_t;
endpackage
`default_nettype wire

// *** stream_fifo.sv ***
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // filling side
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  // draining side
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t next_q;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign o_wr_ready = (q.count != FULL_COUNT);
  assign o_rd_valid = (q.count != '0);
  assign o_rd_data = q.mem[q.rd_ptr];
  assign push = i_wr_valid && o_wr_ready;
  assign pop = o_rd_valid && i_rd_ready;

  // pointers wrap naturally, depth must be a power of two
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.mem[q.wr_ptr] = i_wr_data;
      next_q.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_q.rd_ptr = q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_q.count = q.count + 1'b1;
    end else if (pop && !push) begin
      next_q.count = q.count - 1'b1;
    end
  end

  // state register, storage keeps its contents through reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      q.mem <= q.mem;
      q.wr_ptr <= '0;
      q.rd_ptr <= '0;
      q.count <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// *** tx_data_link_slot_inserter.sv ***
`default_nettype none
module tx_data_link_slot_inserter (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // avalon-mm register slave
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // framer mode
  input wire logic i_e1_mode,
  input wire logic i_esf_mode,
  // stream from the transmit framer
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire tx_link_insert_pkg::stream_word_t i_in_word,
  // serial bits from the three hdlc_tx_instance sources
  input wire logic [2:0] i_link_bit,
  output logic [2:0] o_link_take,
  // stream toward the line
  output logic o_out_valid,
  input wire logic i_out_ready,
  output tx_link_insert_pkg::stream_word_t o_out_word
);
  typedef struct packed {
    logic [2:0][7:0] ctl;
    logic [2:0][7:0] mask;
    logic [4:0] frame_num;
    tx_link_insert_pkg::stream_word_t out_word;
    logic out_valid;
    logic ack;
    logic [7:0] rdata;
  } state_t;

  state_t q;
  state_t next_q;
  tx_link_insert_pkg::stream_word_t head;
  logic [$bits(tx_link_insert_pkg::stream_word_t)-1:0] fifo_rd_data;
  logic fifo_rd_valid;
  logic drain;
  logic advance;
  logic [4:0] frame_first;
  logic [4:0] frame_last;
  logic [4:0] cur_num;
  logic [2:0] claim;
  logic [2:0] grant;
  logic req;
  logic [7:0] reg_idx;

  // tests one slot-based link against the current bit
  function automatic logic slot_claims(input logic [7:0] ctl, input logic [7:0] mask,
                                       input logic odd, input tx_link_insert_pkg::stream_word_t w);
    logic frame_ok;
    logic [2:0] mask_idx;
    // frame parity gate, both selects low blocks the slot claim entirely
    frame_ok = odd ? ctl[tx_link_insert_pkg::BIT_ODD] : ctl[tx_link_insert_pkg::BIT_EVEN];
    // bit_pos 0 is the first transmitted bit, which maps to mask bit 7
    mask_idx = tx_link_insert_pkg::MASK_FIRST_BIT - w.bit_pos;
    // slot field compared as a plain binary index
    return frame_ok
        && (ctl[tx_link_insert_pkg::SLOT_MSB:tx_link_insert_pkg::SLOT_LSB] == w.slot)
        && mask[mask_idx];
  endfunction

  // input buffering, back-pressure reaches the framer through o_in_ready
  stream_fifo #(
    .WIDTH($bits(tx_link_insert_pkg::stream_word_t)),
    .DEPTH(tx_link_insert_pkg::FIFO_DEPTH)
  ) u_in_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_wr_valid(i_in_valid),
    .o_wr_ready(o_in_ready),
    .i_wr_data(i_in_word),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(drain),
    .o_rd_data(fifo_rd_data)
  );

  // output stage may take a word when empty or being emptied
  assign head = tx_link_insert_pkg::stream_word_t'(fifo_rd_data);
  assign drain = !q.out_valid || i_out_ready;
  assign advance = fifo_rd_valid && drain;

  // multiframe numbering bounds per line mode
  always_comb begin
    if (i_e1_mode) begin
      frame_first = tx_link_insert_pkg::E1_FRAME_FIRST;
      frame_last = tx_link_insert_pkg::E1_FRAME_LAST;
    end else if (i_esf_mode) begin
      frame_first = tx_link_insert_pkg::T1_FRAME_FIRST;
      frame_last = tx_link_insert_pkg::ESF_FRAME_LAST;
    end else begin
      frame_first = tx_link_insert_pkg::T1_FRAME_FIRST;
      frame_last = tx_link_insert_pkg::SF_FRAME_LAST;
    end
  end

  // frame number of the head bit, stepped on each frame start
  always_comb begin
    cur_num = q.frame_num;
    if (head.frame_start) begin
      if (head.mf_start || (q.frame_num == frame_last)) begin
        cur_num = frame_first;
      end else begin
        cur_num = q.frame_num + 5'h01;
      end
    end
  end

  // per-link claims on the head bit
  always_comb begin
    claim[0] = slot_claims(q.ctl[0], q.mask[0], cur_num[0], head);
    // framer-chosen positions in T1, software keeps the selects low then
    if (q.ctl[0][tx_link_insert_pkg::BIT_FRAMER_POS] && !i_e1_mode && head.framer_pos) begin
      claim[0] = 1'b1;
    end
    claim[1] = slot_claims(q.ctl[1], q.mask[1], cur_num[0], head);
    claim[2] = slot_claims(q.ctl[2], q.mask[2], cur_num[0], head);
  end

  // fixed priority so one source owns each bit
  always_comb begin
    grant = 3'h0;
    if (claim[0]) begin
      grant = 3'h1;
    end else if (claim[1]) begin
      grant = 3'h2;
    end else if (claim[2]) begin
      grant = 3'h4;
    end
  end

  // each source is pulled only when its bit is really sent
  assign o_link_take = advance ? grant : 3'h0;

  // avalon handshake, one wait cycle on every access
  assign req = i_avs_read || i_avs_write;
  assign reg_idx = i_avs_address[9:2];
  assign o_avs_waitrequest = req && !q.ack;
  assign o_avs_readdata = {24'h000000, q.rdata};
  assign o_out_valid = q.out_valid;
  assign o_out_word = q.out_word;

  // next state
  always_comb begin
    next_q = q;
    // output stage
    if (advance) begin
      next_q.out_word = head;
      next_q.out_valid = 1'b1;
      next_q.frame_num = cur_num;
      // replace the data bit with the winning link's bit
      if (grant[0]) begin
        next_q.out_word.data = i_link_bit[0];
      end else if (grant[1]) begin
        next_q.out_word.data = i_link_bit[1];
      end else if (grant[2]) begin
        next_q.out_word.data = i_link_bit[2];
      end
    end else if (i_out_ready) begin
      next_q.out_valid = 1'b0;
    end
    // wait-cycle flag, ends the access on the following edge
    next_q.ack = req && !q.ack;
    // read data captured in the wait cycle, unmapped reads give zero
    if (i_avs_read && !q.ack) begin
      unique case (reg_idx)
        tx_link_insert_pkg::IDX_LINK1_CTL: next_q.rdata = q.ctl[0];
        tx_link_insert_pkg::IDX_LINK1_MASK: next_q.rdata = q.mask[0];
        tx_link_insert_pkg::IDX_LINK2_CTL: next_q.rdata = q.ctl[1];
        tx_link_insert_pkg::IDX_LINK2_MASK: next_q.rdata = q.mask[1];
        tx_link_insert_pkg::IDX_LINK3_CTL: next_q.rdata = q.ctl[2];
        tx_link_insert_pkg::IDX_LINK3_MASK: next_q.rdata = q.mask[2];
        tx_link_insert_pkg::IDX_STATUS: next_q.rdata = {3'h0, q.frame_num};
        default: next_q.rdata = 8'h00;
      endcase
    end
    // writes land on the edge that ends the access, low byte lane only
    if (i_avs_write && q.ack && i_avs_byteenable[0]) begin
      unique case (reg_idx)
        tx_link_insert_pkg::IDX_LINK1_CTL: next_q.ctl[0] = i_avs_writedata[7:0];
        tx_link_insert_pkg::IDX_LINK1_MASK: next_q.mask[0] = i_avs_writedata[7:0];
        tx_link_insert_pkg::IDX_LINK2_CTL: begin
          next_q.ctl[1] = i_avs_writedata[7:0] & tx_link_insert_pkg::CTL_WMASK_LINK23;
        end
        tx_link_insert_pkg::IDX_LINK2_MASK: next_q.mask[1] = i_avs_writedata[7:0];
        tx_link_insert_pkg::IDX_LINK3_CTL: begin
          next_q.ctl[2] = i_avs_writedata[7:0] & tx_link_insert_pkg::CTL_WMASK_LINK23;
        end
        tx_link_insert_pkg::IDX_LINK3_MASK: next_q.mask[2] = i_avs_writedata[7:0];
        default: next_q.rdata = q.rdata;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      q.ctl[0] <= tx_link_insert_pkg::CTL1_RESET;
      q.ctl[1] <= tx_link_insert_pkg::CTL_RESET;
      q.ctl[2] <= tx_link_insert_pkg::CTL_RESET;
      q.mask <= {3{tx_link_insert_pkg::MASK_RESET}};
      q.frame_num <= tx_link_insert_pkg::FRAME_NUM_RESET;
      q.out_word <= '0;
      q.out_valid <= 1'b0;
      q.ack <= 1'b0;
      q.rdata <= 8'h00;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// *** tx_link_insert_asserts.sv ***
`default_nettype none
module tx_link_insert_asserts (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // watched ports
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [2:0] i_link_bit,
  input wire logic [2:0] o_link_take,
  input wire logic o_out_valid,
  input wire logic i_out_ready,
  input wire tx_link_insert_pkg::stream_word_t o_out_word
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // bus answer timing and width
  wait_one_a: assert property (o_avs_waitrequest |=> !o_avs_waitrequest) else $error("long wait");
  read_width_a: assert property (o_avs_readdata[31:8] == 24'h0) else $error("wide read");
  // one winner, taken only as the word moves out
  take_one_a: assert property ($onehot0(o_link_take)) else $error("two takes");
  take_move_a: assert property (|o_link_take |-> !o_out_valid || i_out_ready)
    else $error("take in stall");
  // a taken bit lands in the next output word
  link_one_a: assert property (o_link_take[0] |=> o_out_word.data == $past(i_link_bit[0]))
    else $error("link 1 bit");
  link_two_a: assert property (o_link_take[1] |=> o_out_word.data == $past(i_link_bit[1]))
    else $error("link 2 bit");
  link_three_a: assert property (o_link_take[2] |=> o_out_word.data == $past(i_link_bit[2]))
    else $error("link 3 bit");
  // a stalled word stands unchanged
  stall_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_word))
    else $error("word moved");
endmodule
bind tx_data_link_slot_inserter tx_link_insert_asserts i_tx_link_insert_asserts (.i_sys_clk,
  .i_reset_n, .o_avs_readdata, .o_avs_waitrequest, .i_link_bit, .o_link_take, .o_out_valid,
  .i_out_ready, .o_out_word);
`default_nettype wire

// *** link_source_model.sv ***
`default_nettype none
module link_source_model #(
  parameter logic [23:0] PAT = 24'h000000
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // serial bits of the three sources
  input wire logic [2:0] i_take,
  output logic [2:0] o_bit
);
  logic [2:0] cnt [3];
  // each source steps through its own byte as its bit is taken
  always_ff @(posedge i_sys_clk)
    for (int k = 0; k < 3; k++) cnt[k] <= !i_reset_n ? 3'h0 : cnt[k] + {2'h0, i_take[k]};
  always_comb
    for (int k = 0; k < 3; k++) o_bit[k] = PAT[8 * k + cnt[k]];
endmodule
`default_nettype wire

// *** tb_tx_data_link_slot_inserter.sv ***
`default_nettype none
module tb_tx_data_link_slot_inserter;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] PAT = 24'h963CA5;
  localparam logic [4:0] SL [4] = '{5'h00, 5'h05, 5'h17, 5'h1F};
  logic i_sys_clk = 1'h0, i_reset_n = 1'h0, i_avs_read = 1'h0, i_avs_write = 1'h0;
  logic i_e1_mode = 1'h0, i_esf_mode = 1'h0, i_in_valid = 1'h0, i_out_ready = 1'h1;
  logic [9:0] i_avs_address = 10'h000;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
  logic [3:0] i_avs_byteenable = 4'h0;
  logic [2:0] i_link_bit, o_link_take, tcnt [3] = '{default: 3'h0};
  logic o_avs_waitrequest, o_in_ready, o_out_valid;
  logic [7:0] q, ctl [3] = '{8'h20, 8'h00, 8'h00}, msk [3] = '{default: 8'h00};
  logic [4:0] fnum = 5'h00;
  tx_link_insert_pkg::stream_word_t i_in_word = '0, o_out_word, nw, expq [$];
  int mismatches = 0, samples_checked = 0, cyc = 0, win;
  tx_data_link_slot_inserter i_tx_data_link_slot_inserter (.i_sys_clk, .i_reset_n,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .i_e1_mode, .i_esf_mode, .i_in_valid, .o_in_ready,
    .i_in_word, .i_link_bit, .o_link_take, .o_out_valid, .i_out_ready, .o_out_word);
  link_source_model #(.PAT(PAT)) i_link_source_model (.i_sys_clk, .i_reset_n,
    .i_take(o_link_take), .o_bit(i_link_bit));
  always #10 i_sys_clk = ~i_sys_clk;
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, d, input logic be);
    @(posedge i_sys_clk);
    i_avs_address <= {a, 2'h0};
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= {3'h0, be};
    do @(posedge i_sys_clk); while (o_avs_waitrequest);
    q = o_avs_readdata[7:0];
    i_avs_read <= 1'h0;
    i_avs_write <= 1'h0;
  endtask
  // program all links and mirror them
  task automatic cfg(input logic [47:0] v);
    for (int k = 0; k < 3; k++) begin
      ctl[k] = v[47 - 16 * k -: 8] & (k == 0 ? 8'hFF : 8'hDF);
      msk[k] = v[39 - 16 * k -: 8];
      bus(1'h1, 8'h38 + 8'(2 * k), ctl[k], 1'h1);
      bus(1'h1, 8'h39 + 8'(2 * k), msk[k], 1'h1);
    end
  endtask
  // expected word for the one just accepted
  task automatic predict;
    if (nw.frame_start)
      fnum = nw.mf_start || fnum == (i_e1_mode ? 5'h0F : i_esf_mode ? 5'h18 : 5'h0C) ?
        {4'h0, !i_e1_mode} : fnum + 5'h01;
    win = -1;
    for (int k = 2; k >= 0; k--)
      if ((fnum[0] ? ctl[k][6] : ctl[k][7]) && nw.slot == ctl[k][4:0] && msk[k][7 - nw.bit_pos])
        win = k;
    if (!i_e1_mode && ctl[0][5] && nw.framer_pos) win = 0;
    expq.push_back(nw);
    if (win >= 0) begin
      expq[$].data = PAT[8 * win + tcnt[win]];
      tcnt[win]++;
    end
  endtask
  task automatic put;
    i_in_valid <= 1'h1;
    i_in_word <= nw;
    do @(posedge i_sys_clk); while (!o_in_ready);
    predict;
  endtask
  // frames of four slots, then drain
  task automatic frames(input int nf, input string name);
    for (int f = 0; f < nf; f++)
      for (int i = 0; i < 32; i++) begin
        nw = {i[0], i == 0, i == 0 && f == 0, SL[i / 8], 3'(i), i == 3};
        put;
      end
    i_in_valid <= 1'h0;
    repeat (300) if (expq.size() != 0) @(posedge i_sys_clk);
    chk(expq.size(), 0);
    $display("test %s done", name);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      bus(1'h0, 8'h38 + 8'(i), 8'h00, 1'h1);
      chk(q, i == 0 ? 8'h20 : 8'h00);
    end
    bus(1'h1, 8'h3C, 8'hFF, 1'h1);
    ctl[2] = 8'hDF;
    bus(1'h1, 8'h3B, 8'h5A, 1'h0);
    bus(1'h1, 8'h10, 8'h5A, 1'h1);
    bus(1'h0, 8'h3C, 8'h00, 1'h1);
    chk(q, 8'hDF);
    bus(1'h0, 8'h3B, 8'h00, 1'h1);
    chk(q, 8'h00);
    bus(1'h0, 8'h10, 8'h00, 1'h1);
    chk(q, 8'h00);
    $display("test regs done");
  endtask
  // fill the buffer against a stalled line
  task automatic t_fifo;
    int n = 0;
    nw = '0;
    i_out_ready <= 1'h0;
    i_in_valid <= 1'h1;
    i_in_word <= nw;
    repeat (12) begin
      @(posedge i_sys_clk);
      if (o_in_ready) begin
        n++;
        predict;
      end
    end
    chk(n, 9);
    i_out_ready <= 1'h1;
    frames(0, "buffer");
  endtask
  task automatic t_e1;
    cfg(48'h8580_4501_D7FF);
    i_e1_mode <= 1'h1;
    frames(17, "e1 parity");
  endtask
  task automatic t_prio;
    cfg(48'hC50F_C53C_C5FF);
    i_e1_mode <= 1'h0;
    frames(13, "priority");
  endtask
  task automatic t_esf;
    cfg(48'h2000_05FF_9781);
    i_esf_mode <= 1'h1;
    frames(25, "framer positions");
    // status shows the frame number of the last word sent
    bus(1'h0, 8'h3E, 8'h00, 1'h1);
    chk(q, {3'h0, fnum});
  endtask
  // compare each outgoing word, and cut a hang short
  always @(posedge i_sys_clk) begin
    cyc++;
    if (i_reset_n && o_out_valid && i_out_ready)
      chk({20'h0, o_out_word}, expq.size() ? {20'h0, expq.pop_front()} : '1);
    if (cyc == 20000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_reset_n <= 1'h1;
    t_regs;
    t_fifo;
    t_e1;
    t_prio;
    t_esf;
    finish_test;
  end
endmodule
`default_nettype wire
